// ### srack_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the link between the host controller and the device.
module srack_asserts (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Link signals between the two ends.
    input wire logic [3:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic cs_n,
    input wire logic [2:0] ack_n,
    input wire logic grant_in_n,
    input wire logic grant_out_n,
    input wire logic [7:0] rdata,
    input wire logic [2:0] req_oe,
    input wire logic [2:0] req_line_n
);
    logic ack_any;
    logic claim;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // An acknowledge is claimed when the device has that type posted.
    assign ack_any = (ack_n != 3'h7) && rd;
    assign claim = ack_any && !grant_in_n && ((~ack_n & req_oe) != 3'h0);

    ////////////////////////////////////////////////////////////////
    property p_ack_read;
        (ack_n != 3'h7) |-> rd && cs_n && $onehot(~ack_n);
    endproperty
    a_ack_read: assert property (p_ack_read)
        else $error("acknowledge outside a lone read");
    property p_grant_in;
        grant_in_n == &ack_n;
    endproperty
    a_grant_in: assert property (p_grant_in)
        else $error("grant not formed from acknowledges");
    property p_pass;
        ack_any && !grant_in_n && !claim |-> !grant_out_n;
    endproperty
    a_pass: assert property (p_pass)
        else $error("unclaimed grant not passed on");
    property p_pass_src;
        !grant_out_n |-> !grant_in_n && ack_any && !claim;
    endproperty
    a_pass_src: assert property (p_pass_src)
        else $error("grant passed without cause");
    property p_tx_code;
        claim && !ack_n[1] |=> rdata[2:0] == 3'h2;
    endproperty
    a_tx_code: assert property (p_tx_code)
        else $error("transmit vector code wrong");
    property p_modem_code;
        claim && !ack_n[2] |=> rdata[2:0] == 3'h1;
    endproperty
    a_modem_code: assert property (p_modem_code)
        else $error("modem vector code wrong");
    property p_rx_code;
        claim && !ack_n[0] |=> rdata[2:0] inside {3'h3, 3'h7};
    endproperty
    a_rx_code: assert property (p_rx_code)
        else $error("receive vector code wrong");
    property p_drop;
        claim |=> (req_oe & ~$past(ack_n)) == 3'h0;
    endproperty
    a_drop: assert property (p_drop)
        else $error("request kept after acknowledge");
    property p_hold;
        (($past(req_oe) & ~req_oe) != 3'h0) |->
            $past(ack_any || (wr && !cs_n && addr == 4'h4));
    endproperty
    a_hold: assert property (p_hold)
        else $error("request dropped without being taken");
    property p_summary;
        rd && !cs_n && addr == 4'h0 |=> rdata[2:0] == ~$past(req_line_n);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary does not mirror request lines");
endmodule

`default_nettype wire

// ### srack_device.sv
// Notes on behaviour
// [R01] Summary low bits show inverted request lines.
// [R02] Host acknowledges by read with acknowledge input.
// [R03] Any write to end_of_service ends acknowledge.
// [R04] Host reads channel id after acknowledge.
// [R05] Context switch possible by register accesses only.
// [R06] Pending type loads its context register.
// [R07] Context value written to channel_access_select switches.
// [R08] Polled host copies context into channel_access_select.
// [R09] Context: channel low, code middle, status high.
// [R10] Middle code unique per type.
// [R11] Polled end: write back, upper two cleared.
// [R12] Channel registers valid only after switch.
// [R13] Unused acknowledge and grant inputs held high.
// [R14] Chain arbitration only with hardware acknowledges.
// [R15] Open-drain request outputs, shared line monitored.
// [R16] Grant from acknowledges; pass feeds next grant.
// [R17] Post only when fairness bit inactive.
// [R18] Granted pending device claims, drives vector.
// [R19] Granted without pending: pass grant onward.
// [R20] Host loads chip id into vector base.
// [R21] Grant out of chain end flags abort.
// [R22] Vector: base upper five, type code low.
// [R23] Type codes 001, 010, 011, 111.
// [R24] Request stays until acknowledged, then drops.
//
// Implementation choices: the address map and the strobed register port.
`include "srack_params.svh"
`timescale 1ns/1ps
`default_nettype none

module srack_device (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Link to the host.
    srack_if.dev bus,
    // Request events from the channel scanner, one per type.
    input wire logic [2:0] i_req_event,
    input wire logic [5:0] i_req_channel,
    input wire logic i_rx_exception,
    // Service context state.
    output logic o_in_service,
    output logic [1:0] o_service_type,
    output logic [1:0] o_service_channel
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Middle code that names each request type in its context register.
    function automatic logic [2:0] ctx_code(input logic [1:0] t);
        case (t)
            `SRACK_RX: ctx_code = `SRACK_CTX_CODE_RX;
            `SRACK_TX: ctx_code = `SRACK_CTX_CODE_TX;
            default: ctx_code = `SRACK_CTX_CODE_MODEM;
        endcase
    endfunction

    // Offset of the context register for each request type.
    function automatic logic [3:0] ctx_ofs(input logic [1:0] t);
        case (t)
            `SRACK_RX: ctx_ofs = `SRACK_RX_CTX_OFS;
            `SRACK_TX: ctx_ofs = `SRACK_TX_CTX_OFS;
            default: ctx_ofs = `SRACK_MODEM_CTX_OFS;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State.

    srack_pkg::srack_ctx_t state;
    logic [1:0] svc_type;
    logic [1:0] svc_ch;
    logic [2:0] pend;
    logic [2:0] posted;
    logic [2:0] fair_ok;
    logic [2:0] ack_hit;
    logic [2:0] cas_hit;
    logic [2:0] take;
    logic [1:0] ch_saved [3];
    logic [2:0] vec_code [3];
    logic [7:0] ctx_view [3];
    logic [7:0] lvb;
    logic reg_wr;
    logic reg_rd;
    logic any_ack_rd;
    logic idle;
    logic hw_end;
    logic sw_end;
    logic [1:0] take_type;
    logic [2:0] acked_pending;

    assign idle = (state == srack_pkg::SRACK_IDLE);
    // Normal register access needs the chip select; acknowledges come without it.
    assign reg_wr = bus.wr & ~bus.cs_n;
    assign reg_rd = bus.rd & ~bus.cs_n;
    assign any_ack_rd = bus.rd & ~(&bus.ack_n); // R02

    ////////////////////////////////////////////////////////////////////////////
    // Per-type request logic.

    genvar t;
    generate
        for (t = 0; t < 3; t++) begin : g_type
            // Another device holding the shared line low makes posting unfair.
            assign fair_ok[t] = bus.req_line_n[t] | posted[t]; // R15
            // Hardware acknowledge of this type, granted and claimed.
            assign ack_hit[t] = bus.rd & ~bus.ack_n[t] & ~bus.grant_in_n & posted[t] & idle; // R18
            // Context value copied into channel_access_select.
            assign cas_hit[t] = reg_wr && bus.addr == `SRACK_CAS_OFS && pend[t] && idle
                && bus.wdata[4:2] == ctx_code(2'(t)); // R07
            assign take[t] = ack_hit[t] | cas_hit[t];

            // Context register view: pending, in service, waiting, code, channel.
            assign ctx_view[t] = {pend[t],
                (~idle && svc_type == 2'(t)),
                pend[t] & ~fair_ok[t] & ~posted[t],
                ctx_code(2'(t)),
                ch_saved[t]}; // R09 R10

            // Pending flag; a new event wins over the clear of a take.
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pend[t] <= 1'b0;
                end else if (i_req_event[t] && (!pend[t] || take[t])) begin
                    pend[t] <= 1'b1;
                end else if (take[t]) begin
                    pend[t] <= 1'b0; // R24
                end
            end

            // Channel captured when the request is first raised.
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ch_saved[t] <= 2'h0;
                end else if (i_req_event[t] && (!pend[t] || take[t])) begin
                    ch_saved[t] <= i_req_channel[2*t +: 2]; // R06
                end
            end

            // Posting waits for a fair turn and holds until taken.
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    posted[t] <= 1'b0;
                end else if (take[t]) begin
                    posted[t] <= 1'b0; // R24
                end else if (pend[t] && fair_ok[t]) begin
                    posted[t] <= 1'b1; // R17
                end
            end

            // Vector type code fixed at posting time.
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    vec_code[t] <= 3'h0;
                end else if (pend[t] && fair_ok[t] && !posted[t]) begin
                    if (t == 0) begin
                        vec_code[t] <= i_rx_exception ? `SRACK_VEC_RX_EXC : `SRACK_VEC_RX_GOOD;
                    end else if (t == 1) begin
                        vec_code[t] <= `SRACK_VEC_TX; // R23
                    end else begin
                        vec_code[t] <= `SRACK_VEC_MODEM;
                    end
                end
            end
        end
    endgenerate

    // Open-drain drive: enable low on the shared line while posted.
    assign bus.req_oe = posted; // R15 R24

    // Acknowledged types that this device holds posted.
    assign acked_pending = ~bus.ack_n & posted;
    // Grant passes on only when no posted request of the acknowledged type.
    assign bus.grant_out_n = ~(~bus.grant_in_n & any_ack_rd & ~(|acked_pending)); // R19 R14

    ////////////////////////////////////////////////////////////////////////////
    // Service context.

    // Lowest taken type; at most one switch happens per cycle.
    always_comb begin
        take_type = `SRACK_RX;
        if (take[0]) begin
            take_type = `SRACK_RX;
        end else if (take[1]) begin
            take_type = `SRACK_TX;
        end else if (take[2]) begin
            take_type = `SRACK_MODEM;
        end
    end

    // Hardware context ends on any write to end_of_service.
    assign hw_end = state == srack_pkg::SRACK_HW_SERVICE && reg_wr
        && bus.addr == `SRACK_EOS_OFS; // R03
    // Polled context ends on write-back with the upper two bits cleared.
    assign sw_end = state == srack_pkg::SRACK_SW_SERVICE && reg_wr
        && bus.addr == ctx_ofs(svc_type) && bus.wdata[7:6] == 2'h0
        && bus.wdata[4:2] == ctx_code(svc_type); // R11

    // Context state machine.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= srack_pkg::SRACK_IDLE;
        end else begin
            case (state)
                srack_pkg::SRACK_IDLE: begin
                    if (|ack_hit) begin
                        state <= srack_pkg::SRACK_HW_SERVICE; // R18
                    end else if (|cas_hit) begin
                        state <= srack_pkg::SRACK_SW_SERVICE; // R05 R07
                    end
                end
                srack_pkg::SRACK_HW_SERVICE: begin
                    if (hw_end) begin
                        state <= srack_pkg::SRACK_IDLE;
                    end
                end
                srack_pkg::SRACK_SW_SERVICE: begin
                    if (sw_end) begin
                        state <= srack_pkg::SRACK_IDLE;
                    end
                end
                default: state <= srack_pkg::SRACK_IDLE;
            endcase
        end
    end

    // Type and channel of the context being served.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            svc_type <= 2'h0;
            svc_ch <= 2'h0;
        end else if (|take) begin
            svc_type <= take_type;
            svc_ch <= ch_saved[take_type];
        end
    end

    assign o_in_service = ~idle;
    assign o_service_type = svc_type;
    assign o_service_channel = svc_ch;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Vector base, written by the host with its chip identification.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvb <= `SRACK_RESET_BYTE;
        end else if (reg_wr && bus.addr == `SRACK_LVB_OFS) begin
            lvb <= bus.wdata;
        end
    end

    // Read data one cycle after the strobe; claimed acknowledges return the vector.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.rdata <= `SRACK_RESET_BYTE;
        end else if (|ack_hit) begin
            bus.rdata <= {lvb[7:3], vec_code[take_type]}; // R18 R22
        end else if (reg_rd) begin
            case (bus.addr)
                `SRACK_SUMMARY_OFS: bus.rdata <= {5'h00, ~bus.req_line_n}; // R01
                `SRACK_RX_CTX_OFS: bus.rdata <= ctx_view[0]; // R06
                `SRACK_TX_CTX_OFS: bus.rdata <= ctx_view[1];
                `SRACK_MODEM_CTX_OFS: bus.rdata <= ctx_view[2];
                `SRACK_LVB_OFS: bus.rdata <= lvb;
                `SRACK_RX_CH_OFS: bus.rdata <= {6'h00, (!idle && svc_type == `SRACK_RX)
                    ? svc_ch : 2'h0}; // R12
                `SRACK_TX_CH_OFS: bus.rdata <= {6'h00, (!idle && svc_type == `SRACK_TX)
                    ? svc_ch : 2'h0};
                `SRACK_MODEM_CH_OFS: bus.rdata <= {6'h00, (!idle && svc_type == `SRACK_MODEM)
                    ? svc_ch : 2'h0};
                `SRACK_RX_VEC_OFS: bus.rdata <= {lvb[7:3], vec_code[0]};
                `SRACK_TX_VEC_OFS: bus.rdata <= {lvb[7:3], vec_code[1]};
                `SRACK_MODEM_VEC_OFS: bus.rdata <= {lvb[7:3], vec_code[2]};
                default: bus.rdata <= `SRACK_RESET_BYTE;
            endcase
        end else begin
            bus.rdata <= `SRACK_RESET_BYTE;
        end
    end

endmodule

`default_nettype wire

// ### srack_host.sv
`include "srack_params.svh"
`timescale 1ns/1ps
`default_nettype none

module srack_host (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Software port.
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Link to the device.
    srack_if.host bus
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [3:0] target;
    logic [7:0] result;
    logic abort;
    logic rd_wait;
    logic status_rd;
    logic abort_seen;

    assign status_rd = i_rd && i_addr == `SRACK_H_STATUS_OFS;
    // Grant leaving the chain end during an acknowledge means nobody claimed it.
    assign abort_seen = bus.rd & ~(&bus.ack_n) & ~bus.grant_out_n; // R21

    // Target device address for the next link access.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            target <= 4'h0;
        end else if (i_wr && i_addr == `SRACK_H_ADDR_OFS) begin
            target <= i_wdata[3:0];
        end
    end

    // One-cycle link strobes; idle acknowledges rest high.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.addr <= 4'h0;
            bus.wdata <= `SRACK_RESET_BYTE;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.cs_n <= 1'b1;
            bus.ack_n <= `SRACK_ACK_IDLE; // R13
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.cs_n <= 1'b1;
            bus.ack_n <= `SRACK_ACK_IDLE;
            if (i_wr && i_addr == `SRACK_H_WRITE_OFS) begin
                bus.addr <= target;
                bus.wdata <= i_wdata; // R03 R08 R11
                bus.wr <= 1'b1;
                bus.cs_n <= 1'b0;
            end else if (i_wr && i_addr == `SRACK_H_READ_OFS) begin
                bus.addr <= target;
                bus.rd <= 1'b1;
                case (i_wdata[1:0])
                    `SRACK_H_RD_ACK_RX: bus.ack_n <= 3'h6; // R02
                    `SRACK_H_RD_ACK_TX: bus.ack_n <= 3'h5;
                    `SRACK_H_RD_ACK_MODEM: bus.ack_n <= 3'h3;
                    default: bus.cs_n <= 1'b0;
                endcase
            end
        end
    end

    // First chain grant follows any acknowledge.
    assign bus.grant_in_n = &bus.ack_n; // R16

    // Capture the device's answer in the cycle after the read.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_wait <= 1'b0;
            result <= `SRACK_RESET_BYTE;
        end else begin
            rd_wait <= bus.rd;
            if (rd_wait) begin
                result <= bus.rdata; // R04
            end
        end
    end

    // Sticky abort; a new abort wins over the clear by a status read.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            abort <= 1'b0;
        end else if (abort_seen) begin
            abort <= 1'b1; // R21
        end else if (status_rd) begin
            abort <= 1'b0;
        end
    end

    // Software read data, one cycle after the strobe.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `SRACK_RESET_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `SRACK_H_ADDR_OFS: o_rdata <= {4'h0, target};
                `SRACK_H_RESULT_OFS: o_rdata <= result;
                `SRACK_H_STATUS_OFS: o_rdata <= {3'h0, rd_wait, abort, ~bus.req_line_n};
                default: o_rdata <= `SRACK_RESET_BYTE;
            endcase
        end else begin
            o_rdata <= `SRACK_RESET_BYTE;
        end
    end

endmodule

`default_nettype wire

// ### srack_if.sv
`timescale 1ns/1ps
`default_nettype none

interface srack_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic cs_n;
    logic [2:0] ack_n;
    logic grant_in_n;
    logic grant_out_n;
    logic [7:0] rdata;
    logic [2:0] req_oe;
    logic [2:0] req_line_n;

    // Open-drain request lines are pulled high unless the device drives them low.
    assign req_line_n = ~req_oe;

    modport dev (
        input addr, wdata, wr, rd, cs_n, ack_n, grant_in_n, req_line_n,
        output rdata, req_oe, grant_out_n
    );

    modport host (
        output addr, wdata, wr, rd, cs_n, ack_n, grant_in_n,
        input rdata, req_line_n, grant_out_n
    );
endinterface

`default_nettype wire

// ### srack_params.svh
`ifndef SRACK_PARAMS_SVH
`define SRACK_PARAMS_SVH

// Request type indexes, shared by vectors, lines and context registers.
`define SRACK_RX 2'h0
`define SRACK_TX 2'h1
`define SRACK_MODEM 2'h2

// Device register offsets on the four-bit link address.
`define SRACK_SUMMARY_OFS 4'h0
`define SRACK_RX_CTX_OFS 4'h1
`define SRACK_TX_CTX_OFS 4'h2
`define SRACK_MODEM_CTX_OFS 4'h3
`define SRACK_CAS_OFS 4'h4
`define SRACK_EOS_OFS 4'h5
`define SRACK_LVB_OFS 4'h6
`define SRACK_RX_CH_OFS 4'h7
`define SRACK_TX_CH_OFS 4'h8
`define SRACK_MODEM_CH_OFS 4'h9
`define SRACK_RX_VEC_OFS 4'ha
`define SRACK_TX_VEC_OFS 4'hb
`define SRACK_MODEM_VEC_OFS 4'hc

// Context register fields.
`define SRACK_CTX_CH_LSB 0
`define SRACK_CTX_CODE_LSB 2
`define SRACK_CTX_FAIR_BIT 5
`define SRACK_CTX_SERVICE_BIT 6
`define SRACK_CTX_PENDING_BIT 7

// Middle codes of the context registers, one per type.
`define SRACK_CTX_CODE_RX 3'h4
`define SRACK_CTX_CODE_TX 3'h5
`define SRACK_CTX_CODE_MODEM 3'h6

// Vector type codes in the low three vector bits.
`define SRACK_VEC_MODEM 3'h1
`define SRACK_VEC_TX 3'h2
`define SRACK_VEC_RX_GOOD 3'h3
`define SRACK_VEC_RX_EXC 3'h7

// Host controller register offsets on its user port.
`define SRACK_H_ADDR_OFS 3'h0
`define SRACK_H_WRITE_OFS 3'h1
`define SRACK_H_READ_OFS 3'h2
`define SRACK_H_RESULT_OFS 3'h3
`define SRACK_H_STATUS_OFS 3'h4

// Host read command kinds in the low bits of a read order.
`define SRACK_H_RD_PLAIN 2'h0
`define SRACK_H_RD_ACK_RX 2'h1
`define SRACK_H_RD_ACK_TX 2'h2
`define SRACK_H_RD_ACK_MODEM 2'h3

// Reset values.
`define SRACK_RESET_BYTE 8'h00
`define SRACK_ACK_IDLE 3'h7

`endif

// ### srack_pkg.sv
package srack_pkg;

    // Service context of the device.
    typedef enum logic [1:0] {
        SRACK_IDLE,
        SRACK_HW_SERVICE,
        SRACK_SW_SERVICE
    } srack_ctx_t;

    typedef logic [7:0] srack_byte_t;

endpackage

// ### testbench.sv
`include "srack_params.svh"
`timescale 1ns/1ps
`default_nettype none

`define SRACK_CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end

module testbench;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic [2:0] i_req_event = 3'h0;
    logic [5:0] i_req_channel = 6'h00;
    logic i_rx_exception = 1'b0;
    logic o_in_service;
    logic [1:0] o_service_type;
    logic [1:0] o_service_channel;
    logic [7:0] rb;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    srack_if link ();
    srack_device i_srack_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(link),
        .i_req_event(i_req_event), .i_req_channel(i_req_channel),
        .i_rx_exception(i_rx_exception), .o_in_service(o_in_service),
        .o_service_type(o_service_type), .o_service_channel(o_service_channel));
    srack_host i_srack_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .bus(link));
    srack_asserts i_srack_asserts (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .addr(link.addr),
        .wr(link.wr), .rd(link.rd), .cs_n(link.cs_n), .ack_n(link.ack_n),
        .grant_in_n(link.grant_in_n), .grant_out_n(link.grant_out_n),
        .rdata(link.rdata), .req_oe(link.req_oe), .req_line_n(link.req_line_n));

    // Clock and a cycle ceiling that cuts a hang short.
    always #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("MISMATCH %0t run timed out", $time);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Software port accesses and link operations built on them.
    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic hr(input logic [2:0] a);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rb = o_rdata;
    endtask

    task automatic lwr(input logic [3:0] ofs, input logic [7:0] d);
        hw(`SRACK_H_ADDR_OFS, {4'h0, ofs});
        hw(`SRACK_H_WRITE_OFS, d);
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic lrd(input logic [3:0] ofs, input logic [1:0] kind);
        hw(`SRACK_H_ADDR_OFS, {4'h0, ofs});
        hw(`SRACK_H_READ_OFS, {6'h00, kind});
        repeat (5) @(posedge i_mclk);
        hr(`SRACK_H_RESULT_OFS);
    endtask

    task automatic post(input logic [2:0] m, input logic [5:0] ch, input logic x);
        @(posedge i_mclk);
        i_req_event <= m;
        i_req_channel <= ch;
        i_rx_exception <= x;
        @(posedge i_mclk);
        i_req_event <= 3'h0;
        repeat (4) @(posedge i_mclk);
    endtask

    // Hardware acknowledge of a posted type, then the service end.
    task automatic ack_case(input logic [1:0] kind, input logic [7:0] vec,
        input logic [4:0] svc, input logic [3:0] chofs, input logic [7:0] ch);
        lrd(`SRACK_SUMMARY_OFS, kind);
        `SRACK_CHK(rb, vec);
        `SRACK_CHK({o_in_service, o_service_type, o_service_channel}, svc);
        lrd(`SRACK_SUMMARY_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h00);
        lrd(chofs, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, ch);
        lwr(`SRACK_EOS_OFS, 8'h5a);
        `SRACK_CHK(o_in_service, 1'b0);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        lrd(`SRACK_SUMMARY_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h00);
        lwr(`SRACK_LVB_OFS, 8'ha8);
        post(3'h2, 6'h08, 1'b0);
        lrd(`SRACK_SUMMARY_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h02);
        hr(`SRACK_H_STATUS_OFS);
        `SRACK_CHK(rb & 8'h07, 8'h02);
        lrd(`SRACK_TX_CTX_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h96);
        ack_case(`SRACK_H_RD_ACK_TX, 8'haa, 5'h16, `SRACK_TX_CH_OFS, 8'h02);
        post(3'h4, 6'h10, 1'b0);
        lrd(`SRACK_MODEM_CTX_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h99);
        ack_case(`SRACK_H_RD_ACK_MODEM, 8'ha9, 5'h19, `SRACK_MODEM_CH_OFS, 8'h01);
        post(3'h1, 6'h03, 1'b1);
        ack_case(`SRACK_H_RD_ACK_RX, 8'haf, 5'h13, `SRACK_RX_CH_OFS, 8'h03);
        $display("test hardware acknowledge done");
        post(3'h1, 6'h03, 1'b0);
        lrd(`SRACK_RX_CTX_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h93);
        lrd(`SRACK_RX_VEC_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'hab);
        lwr(`SRACK_CAS_OFS, 8'h93);
        `SRACK_CHK({o_in_service, o_service_type, o_service_channel}, 5'h13);
        lrd(`SRACK_RX_CTX_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h53);
        lrd(`SRACK_SUMMARY_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h00);
        lrd(`SRACK_RX_CH_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h03);
        lwr(`SRACK_RX_CTX_OFS, 8'h13);
        `SRACK_CHK(o_in_service, 1'b0);
        post(3'h2, 6'h04, 1'b0);
        lwr(`SRACK_CAS_OFS, 8'h93);
        `SRACK_CHK(o_in_service, 1'b0);
        $display("test polled switch done");
        lrd(`SRACK_SUMMARY_OFS, `SRACK_H_RD_ACK_RX);
        `SRACK_CHK(rb, 8'h00);
        hr(`SRACK_H_STATUS_OFS);
        `SRACK_CHK(rb & 8'h08, 8'h08);
        hr(`SRACK_H_STATUS_OFS);
        `SRACK_CHK(rb & 8'h08, 8'h00);
        $display("test unclaimed acknowledge done");
        post(3'h2, 6'h04, 1'b0);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        lrd(`SRACK_SUMMARY_OFS, `SRACK_H_RD_PLAIN);
        `SRACK_CHK(rb, 8'h00);
        $display("test second reset done");
        conclude();
    end
endmodule

`default_nettype wire
